// file: rtl/astx_top.sv
// Asynchronous serial transmitter with an AXI4-Lite register slave.
// Assumes synchronous inputs on aclk and a divisor-driven baud tick built inside.
`timescale 1ns/1ps

module astx_top import astx_pkg::*; #(
  parameter int DIV_WIDTH = 16,
  parameter int PRESCALE_LOW = 16,
  parameter int PRESCALE_HIGH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic irq
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] tx_control_status;
  logic [7:0] rx_control_status;
  logic [7:0] baud_control;
  logic [7:0] tx_holding_reg;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [7:0] irq_control_reg;
  logic [7:0] peripheral_enable_reg_one;
  logic [7:0] analog_pin_select;
  astx_cfg_t cfg;
  logic holding_full;
  logic ninth_hold;
  logic [1:0] flag_delay;
  logic tx_buffer_free_flag;
  logic shift_reg_empty;
  logic baud_restart;

  assign cfg.transmit_enable = tx_control_status[TXC_TRANSMIT_ENABLE_BIT];
  assign cfg.clocked_mode_select = tx_control_status[TXC_CLOCKED_MODE_BIT];
  assign cfg.serial_port_enable = rx_control_status[RXC_PORT_ENABLE_BIT];
  assign cfg.ninth_bit_enable = tx_control_status[TXC_NINTH_ENABLE_BIT];
  assign cfg.tx_invert = baud_control[BDC_INVERT_BIT];
  assign cfg.baud_wide_divisor = baud_control[BDC_WIDE_BIT];
  assign cfg.baud_high_speed = tx_control_status[TXC_HIGH_SPEED_BIT];

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire lane0 = w_strb[0];
  wire wr_txc = do_write && lane0 && (aw_addr == TX_CONTROL_STATUS_OFF);
  wire wr_rxc = do_write && lane0 && (aw_addr == RX_CONTROL_STATUS_OFF);
  wire wr_bdc = do_write && lane0 && (aw_addr == BAUD_CONTROL_OFF);
  wire wr_hold = do_write && lane0 && (aw_addr == TX_HOLDING_REG_OFF);
  wire wr_dlo = do_write && lane0 && (aw_addr == BAUD_DIVISOR_LOW_OFF);
  wire wr_dhi = do_write && lane0 && (aw_addr == BAUD_DIVISOR_HIGH_OFF);
  wire wr_irq = do_write && lane0 && (aw_addr == IRQ_CONTROL_REG_OFF);
  wire wr_pen = do_write && lane0 && (aw_addr == PERIPHERAL_ENABLE_OFF);
  wire wr_ana = do_write && lane0 && (aw_addr == ANALOG_SELECT_OFF);
  wire addr_ok_w = (aw_addr == TX_CONTROL_STATUS_OFF) || (aw_addr == RX_CONTROL_STATUS_OFF)
    || (aw_addr == BAUD_CONTROL_OFF) || (aw_addr == TX_HOLDING_REG_OFF)
    || (aw_addr == BAUD_DIVISOR_LOW_OFF) || (aw_addr == BAUD_DIVISOR_HIGH_OFF)
    || (aw_addr == IRQ_CONTROL_REG_OFF) || (aw_addr == PERIPHERAL_ENABLE_OFF)
    || (aw_addr == PERIPHERAL_FLAG_OFF) || (aw_addr == ANALOG_SELECT_OFF);

  // Address and data are captured separately, in either order
  // Unmapped addresses are answered with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !aw_take;
      s_axi_wready <= !w_held && !w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok_w ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Status bits 1 (shift_reg_empty) and free flag are not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_control_status <= TXC_RESET;
      rx_control_status <= BYTE_RESET;
      baud_control <= BYTE_RESET;
      baud_divisor_low <= BYTE_RESET;
      baud_divisor_high <= BYTE_RESET;
      irq_control_reg <= BYTE_RESET;
      peripheral_enable_reg_one <= BYTE_RESET;
      analog_pin_select <= ANALOG_SELECT_RESET;
    end else begin
      if (wr_txc) tx_control_status <= {w_data[7:2], shift_reg_empty, w_data[0]};
      else tx_control_status[TXC_SHIFT_EMPTY_BIT] <= shift_reg_empty;
      if (wr_rxc) rx_control_status <= w_data[7:0];
      if (wr_bdc) baud_control <= w_data[7:0];
      if (wr_dlo) baud_divisor_low <= w_data[7:0];
      if (wr_dhi) baud_divisor_high <= w_data[7:0];
      if (wr_irq) irq_control_reg <= w_data[7:0];
      if (wr_pen) peripheral_enable_reg_one <= w_data[7:0];
      if (wr_ana) analog_pin_select <= w_data[7:0];
    end
  end

  // ****************************************
  // Baud tick generator
  // ****************************************
  // 8 or 16 bit divisor
  wire [DIV_WIDTH-1:0] divisor = cfg.baud_wide_divisor
    ? DIV_WIDTH'({baud_divisor_high, baud_divisor_low}) : DIV_WIDTH'(baud_divisor_low);
  wire [5:0] prescale = cfg.baud_high_speed ? 6'(PRESCALE_HIGH - 1) : 6'(PRESCALE_LOW - 1);
  logic [DIV_WIDTH-1:0] div_cnt;
  logic [5:0] pre_cnt;
  logic baud_tick;
  wire tx_active = cfg.transmit_enable && !cfg.clocked_mode_select && cfg.serial_port_enable;

  // counters restart on load, so the start bit is a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_active || baud_restart) begin
      div_cnt <= '0;
      pre_cnt <= 6'h00;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (div_cnt >= divisor) begin
        div_cnt <= '0;
        if (pre_cnt >= prescale) begin
          pre_cnt <= 6'h00;
          baud_tick <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 6'h01;
        end
      end else begin
        div_cnt <= div_cnt + DIV_WIDTH'(1);
      end
    end
  end

  // ****************************************
  // Holding register and shifter
  // ****************************************
  // Frame state and shifter; the shifter idles at all ones
  astx_state_t state;
  logic [10:0] tx_shifter;
  logic [3:0] bits_left;
  wire [3:0] frame_len = cfg.ninth_bit_enable ? 4'(FRAME_BITS_9) : 4'(FRAME_BITS_8);
  wire last_bit = (bits_left == 4'h1);
  wire holding_set = wr_hold && tx_active;
  // Restart the baud phase on the edge that enters LOAD, from idle or
  // straight after a stop bit, so the new frame starts on a tick boundary
  assign baud_restart = holding_full && ((state == ASTX_IDLE)
    || (state == ASTX_SHIFT && baud_tick && last_bit));

  // no parity is formed; frame holds only data and framing
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_active) begin
      state <= ASTX_IDLE;
      tx_shifter <= 11'h7ff;
      bits_left <= 4'h0;
      holding_full <= 1'b0;
      tx_holding_reg <= 8'h00;
      ninth_hold <= 1'b0;
      shift_reg_empty <= 1'b1;
    end else begin
      if (holding_set) begin
        holding_full <= 1'b1;
        tx_holding_reg <= w_data[7:0];
      end
      case (state)
        ASTX_IDLE: begin
          if (holding_full) begin
            state <= ASTX_LOAD;
          end
        end
        ASTX_LOAD: begin
          // stop, data, start from top to bottom
          tx_shifter <= cfg.ninth_bit_enable
            ? {1'b1, ninth_hold, tx_holding_reg, 1'b0}
            : {2'b11, tx_holding_reg, 1'b0};
          bits_left <= frame_len;
          if (!holding_set) holding_full <= 1'b0;
          shift_reg_empty <= 1'b0;
          state <= ASTX_SHIFT;
        end
        ASTX_SHIFT: begin
          if (baud_tick) begin
            tx_shifter <= {1'b1, tx_shifter[10:1]};
            bits_left <= bits_left - 4'h1;
            if (last_bit) begin
              // queued character follows stop bit at once
              state <= holding_full ? ASTX_LOAD : ASTX_IDLE;
              shift_reg_empty <= 1'b1;
            end
          end
        end
        default: state <= ASTX_IDLE;
      endcase
      // ninth bit taken from the control register at write time
      if (holding_set) ninth_hold <= tx_control_status[TXC_NINTH_VALUE_BIT];
    end
  end

  // ****************************************
  // Buffer-free flag and interrupt
  // ****************************************
  // A character waits only while the shifter is still busy
  wire char_queued = holding_full && !shift_reg_empty;
  // flag follows buffer state one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_delay <= 2'b00;
      tx_buffer_free_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      flag_delay <= {flag_delay[0], holding_set};
      if (!tx_active) tx_buffer_free_flag <= cfg.transmit_enable;
      else if (flag_delay[FLAG_DELAY_CYCLES-1] || !holding_set)
        tx_buffer_free_flag <= !char_queued;
      irq <= tx_buffer_free_flag && peripheral_enable_reg_one[PER_TX_BIT]
        && irq_control_reg[IRQ_GLOBAL_BIT] && irq_control_reg[IRQ_GROUP_BIT];
    end
  end

  // ****************************************
  // Pin driver
  // ****************************************
  wire pin_invert = cfg.tx_invert && !cfg.clocked_mode_select;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_out <= 1'b1;
      tx_pin_oe <= 1'b0;
    end else begin
      tx_pin_out <= tx_shifter[0] ^ pin_invert;
      tx_pin_oe <= tx_active && !analog_pin_select[ANA_TX_PIN_BIT];
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // Upper bits of every register read as zero
  wire [7:0] peripheral_flag_reg_one = {3'b000, tx_buffer_free_flag, 4'h0};
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == TX_CONTROL_STATUS_OFF[7:2]) rd_byte = tx_control_status;
    else if (s_axi_araddr[7:2] == RX_CONTROL_STATUS_OFF[7:2]) rd_byte = rx_control_status;
    else if (s_axi_araddr[7:2] == BAUD_CONTROL_OFF[7:2]) rd_byte = baud_control;
    else if (s_axi_araddr[7:2] == TX_HOLDING_REG_OFF[7:2]) rd_byte = tx_holding_reg;
    else if (s_axi_araddr[7:2] == BAUD_DIVISOR_LOW_OFF[7:2]) rd_byte = baud_divisor_low;
    else if (s_axi_araddr[7:2] == BAUD_DIVISOR_HIGH_OFF[7:2]) rd_byte = baud_divisor_high;
    else if (s_axi_araddr[7:2] == IRQ_CONTROL_REG_OFF[7:2]) rd_byte = irq_control_reg;
    else if (s_axi_araddr[7:2] == PERIPHERAL_ENABLE_OFF[7:2]) rd_byte = peripheral_enable_reg_one;
    else if (s_axi_araddr[7:2] == PERIPHERAL_FLAG_OFF[7:2]) rd_byte = peripheral_flag_reg_one;
    else if (s_axi_araddr[7:2] == ANALOG_SELECT_OFF[7:2]) rd_byte = analog_pin_select;
    else begin
      rd_byte = 8'h00;
      rd_ok = 1'b0;
    end
  end

  // One read at a time; answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : astx_top

// file: rtl/astx_pkg.sv
// Package for the asynchronous serial transmitter block.
// Assumes a single 100 MHz system clock and an AXI4-Lite register master.
package astx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] TX_CONTROL_STATUS_OFF = 8'h00;
  localparam logic [7:0] RX_CONTROL_STATUS_OFF = 8'h04;
  localparam logic [7:0] BAUD_CONTROL_OFF = 8'h08;
  localparam logic [7:0] TX_HOLDING_REG_OFF = 8'h0c;
  localparam logic [7:0] BAUD_DIVISOR_LOW_OFF = 8'h10;
  localparam logic [7:0] BAUD_DIVISOR_HIGH_OFF = 8'h14;
  localparam logic [7:0] IRQ_CONTROL_REG_OFF = 8'h18;
  localparam logic [7:0] PERIPHERAL_ENABLE_OFF = 8'h1c;
  localparam logic [7:0] PERIPHERAL_FLAG_OFF = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  // tx_control_status
  localparam int TXC_CLOCKED_MODE_BIT = 4;
  localparam int TXC_TRANSMIT_ENABLE_BIT = 5;
  localparam int TXC_NINTH_ENABLE_BIT = 6;
  localparam int TXC_HIGH_SPEED_BIT = 2;
  localparam int TXC_SHIFT_EMPTY_BIT = 1;
  localparam int TXC_NINTH_VALUE_BIT = 0;
  // rx_control_status
  localparam int RXC_PORT_ENABLE_BIT = 7;
  // baud_control
  localparam int BDC_INVERT_BIT = 4;
  localparam int BDC_WIDE_BIT = 3;
  // irq_control_reg
  localparam int IRQ_GLOBAL_BIT = 7;
  localparam int IRQ_GROUP_BIT = 6;
  // peripheral enable / flag registers
  localparam int PER_TX_BIT = 4;
  // analog select register
  localparam logic [7:0] ANALOG_SELECT_OFF = 8'h24;
  localparam int ANA_TX_PIN_BIT = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] TXC_RESET = 8'h02;
  localparam logic [7:0] ANALOG_SELECT_RESET = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Flag update delay after a holding write, in aclk cycles
  localparam int FLAG_DELAY_CYCLES = 2;
  // Frame length in bits: start + data + one stop
  localparam int FRAME_BITS_8 = 10;
  localparam int FRAME_BITS_9 = 11;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ASTX_IDLE = 3'b001,
    ASTX_LOAD = 3'b010,
    ASTX_SHIFT = 3'b100
  } astx_state_t;

  typedef struct packed {
    logic transmit_enable;
    logic clocked_mode_select;
    logic serial_port_enable;
    logic ninth_bit_enable;
    logic tx_invert;
    logic baud_wide_divisor;
    logic baud_high_speed;
  } astx_cfg_t;

endpackage : astx_pkg

// file: tb/astx_top_asserts.sv
// Checker for the serial transmitter ports: bus handshakes and line timing.
// Assumes it is bound into astx_top and sees only that module's ports.
`timescale 1ns/1ps
module astx_top_asserts import astx_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Port relations
  // ****************************************
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    tx_pin_out && !tx_pin_oe && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not quiet in reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10} &&
    (s_axi_rresp == 2'b00 || s_axi_rdata == 32'h0)) else $error("bad read response");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_bit_length: assert property (tx_pin_oe && $past(tx_pin_oe) && $changed(tx_pin_out)
    |=> $stable(tx_pin_out) [*3]) else $error("line bit too short");
endmodule : astx_top_asserts

bind astx_top astx_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .irq(irq));

// file: tb/astx_rx_model.sv
// Remote asynchronous receiver on the transmit line.
// Assumes the line reads high through a pull-up while the pin is released.
`timescale 1ns/1ps
module astx_rx_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic line,
  input wire logic invert,
  input wire logic nine,
  input wire logic listen,
  output logic [8:0] rx_data,
  output int rx_count,
  output logic rx_ok
);
  logic lvl;
  // Undo the polarity choice before decoding
  assign lvl = line ^ invert;
  // Frame decoder sampling at mid-bit
  initial begin
    logic [8:0] sh;
    rx_data = 9'h000;
    rx_count = 0;
    rx_ok = 1'b1;
    forever begin
      @(posedge aclk);
      if (listen && lvl === 1'b0) begin
        sh = 9'h000;
        repeat (BIT_CYCLES / 2) @(posedge aclk);
        if (lvl !== 1'b0) rx_ok = 1'b0;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_CYCLES) @(posedge aclk);
          sh[i] = lvl;
        end
        repeat (BIT_CYCLES) @(posedge aclk);
        if (lvl !== 1'b1) rx_ok = 1'b0;
        rx_data = sh;
        rx_count++;
      end
    end
  end
endmodule : astx_rx_model

// file: tb/async_serial_transmitter_tb.sv
// Self-checking bench for the serial transmitter over its register bus.
// Assumes divisor 1 with high speed, so one bit lasts 8 clocks.
`timescale 1ns/1ps
module async_serial_transmitter_tb;
  import astx_pkg::*;
  localparam int BIT_CYCLES = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, irq, line, rx_ok;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] rx_data;
  logic inv = 1'b0;
  logic nine = 1'b0;
  logic listen = 1'b1;
  int rx_count;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] v;
  logic [1:0] r;
  always #5 aclk = ~aclk;
  // Released pin is pulled up
  assign line = pin_oe ? pin_out : 1'b1;
  astx_top #(.DIV_WIDTH(16), .PRESCALE_LOW(16), .PRESCALE_HIGH(4)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_pin_out(pin_out), .tx_pin_oe(pin_oe), .irq(irq));
  astx_rx_model #(.BIT_CYCLES(BIT_CYCLES)) u_rx (.aclk(aclk), .line(line), .invert(inv),
    .nine(nine), .listen(listen), .rx_data(rx_data), .rx_count(rx_count), .rx_ok(rx_ok));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_up();
    mismatches++;
    wrap_up();
  endtask : give_up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) give_up();
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) give_up();
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wait_rx(input int target);
    int n;
    for (n = 0; n < 4000 && rx_count < target; n++) @(posedge aclk);
    if (n == 4000) give_up();
  endtask : wait_rx
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(TX_CONTROL_STATUS_OFF, v, r);
    chk("control reset", v, {24'h0, TXC_RESET});
    rd(ANALOG_SELECT_OFF, v, r);
    chk("analog reset", v, {24'h0, ANALOG_SELECT_RESET});
    rd(8'h3c, v, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    wr(8'h3c, 8'h00);
    chk("unmapped wr resp", {30'h0, r}, 32'h2);
  endtask : t_reset
  task automatic t_setup();
    wr(BAUD_DIVISOR_LOW_OFF, 8'h01);
    wr(BAUD_DIVISOR_HIGH_OFF, 8'h00);
    wr(TX_CONTROL_STATUS_OFF, 8'h04);
    wr(RX_CONTROL_STATUS_OFF, 8'h80);
    wr(ANALOG_SELECT_OFF, 8'h00);
    wr(TX_CONTROL_STATUS_OFF, 8'h24);
    repeat (4) @(posedge aclk);
    chk("pin driven", {31'h0, pin_oe}, 32'h1);
    chk("idle mark", {31'h0, line}, 32'h1);
    rd(PERIPHERAL_FLAG_OFF, v, r);
    chk("free flag on enable", {31'h0, v[PER_TX_BIT]}, 32'h1);
  endtask : t_setup
  task automatic t_single();
    wr(TX_HOLDING_REG_OFF, 8'ha5);
    repeat (2) @(posedge aclk);
    rd(TX_CONTROL_STATUS_OFF, v, r);
    chk("shifter busy", {31'h0, v[TXC_SHIFT_EMPTY_BIT]}, 32'h0);
    wait_rx(1);
    chk("single char", {23'h0, rx_data}, 32'h0a5);
    chk("frame ok", {31'h0, rx_ok}, 32'h1);
    repeat (BIT_CYCLES) @(posedge aclk);
    rd(TX_CONTROL_STATUS_OFF, v, r);
    chk("shifter empty", {31'h0, v[TXC_SHIFT_EMPTY_BIT]}, 32'h1);
  endtask : t_single
  task automatic t_back_to_back();
    wr(TX_HOLDING_REG_OFF, 8'h01);
    wr(TX_HOLDING_REG_OFF, 8'hfe);
    rd(PERIPHERAL_FLAG_OFF, v, r);
    chk("flag while queued", {31'h0, v[PER_TX_BIT]}, 32'h0);
    wait_rx(2);
    chk("first char", {23'h0, rx_data}, 32'h001);
    // Queued character moves only once the stop bit has ended
    repeat (BIT_CYCLES) @(posedge aclk);
    rd(PERIPHERAL_FLAG_OFF, v, r);
    chk("flag after move", {31'h0, v[PER_TX_BIT]}, 32'h1);
    wait_rx(3);
    chk("queued char", {23'h0, rx_data}, 32'h0fe);
  endtask : t_back_to_back
  task automatic t_nine();
    nine = 1'b1;
    wr(TX_CONTROL_STATUS_OFF, 8'h65);
    wr(TX_HOLDING_REG_OFF, 8'h3c);
    wait_rx(4);
    chk("nine bit char", {23'h0, rx_data}, 32'h13c);
    wr(TX_CONTROL_STATUS_OFF, 8'h24);
    nine = 1'b0;
  endtask : t_nine
  task automatic t_invert();
    listen = 1'b0;
    wr(BAUD_CONTROL_OFF, 8'h10);
    repeat (10) @(posedge aclk);
    chk("inverted idle", {31'h0, line}, 32'h0);
    inv = 1'b1;
    listen = 1'b1;
    wr(TX_HOLDING_REG_OFF, 8'h5a);
    wait_rx(5);
    chk("inverted char", {23'h0, rx_data}, 32'h05a);
    listen = 1'b0;
    wr(BAUD_CONTROL_OFF, 8'h00);
    repeat (10) @(posedge aclk);
    inv = 1'b0;
    listen = 1'b1;
    chk("plain idle", {31'h0, line}, 32'h1);
  endtask : t_invert
  task automatic t_disable();
    wr(TX_CONTROL_STATUS_OFF, 8'h04);
    repeat (4) @(posedge aclk);
    chk("released off", {31'h0, pin_oe}, 32'h0);
    wr(TX_HOLDING_REG_OFF, 8'h77);
    repeat (200) @(posedge aclk);
    chk("no frame off", rx_count, 32'd5);
    wr(TX_CONTROL_STATUS_OFF, 8'h34);
    repeat (4) @(posedge aclk);
    chk("released clocked", {31'h0, pin_oe}, 32'h0);
    wr(TX_CONTROL_STATUS_OFF, 8'h24);
    wr(PERIPHERAL_FLAG_OFF, 8'h00);
    chk("flag write resp", {30'h0, r}, 32'h0);
    rd(PERIPHERAL_FLAG_OFF, v, r);
    chk("flag read only", {31'h0, v[PER_TX_BIT]}, 32'h1);
  endtask : t_disable
  task automatic t_irq();
    wr(PERIPHERAL_ENABLE_OFF, 8'h10);
    repeat (3) @(posedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(IRQ_CONTROL_REG_OFF, 8'hc0);
    repeat (3) @(posedge aclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(IRQ_CONTROL_REG_OFF, 8'h40);
    repeat (3) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_irq
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_setup();
    t_single();
    t_back_to_back();
    t_nine();
    t_invert();
    t_disable();
    t_irq();
    wrap_up();
  end
endmodule : async_serial_transmitter_tb
